// ### rtl/gtm_pkg.sv
// Package of constants for the gate array test mode decoder
package gtm_pkg;
  // Number of user outputs and scan chain flip-flops
  localparam int GTM_OUT_W = 16;
  localparam int GTM_CHAIN_W = 16;
  // Ring oscillator half period in system clocks
  localparam int GTM_OSC_HALF = 4;
  localparam logic [3:0] GTM_OSC_HALF_M1 = 4'h3;
  // Reset values
  localparam logic [15:0] GTM_CHAIN_RST = 16'h0000;
  localparam logic [15:0] GTM_OUT_RST = 16'h0000;
  typedef enum logic [2:0] {
    GTM_NORMAL, GTM_FORCE, GTM_HIZ, GTM_IDDQ, GTM_CLEAR, GTM_SCAN
  } gtm_mode_t;
endpackage

// ### rtl/gtm_ring_osc.sv
// Ring oscillator model: toggling divider gated by enable
`timescale 1ns/100ps
module gtm_ring_osc (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic enable_in,
  output logic osc_out
);
  import gtm_pkg::*;
  logic [3:0] cnt_r;
  logic osc_r;
  // Free counter toggles the output while enabled; held low when off
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r <= 4'h0;
      osc_r <= 1'b0;
    end else if (!enable_in) begin
      cnt_r <= 4'h0;
      osc_r <= 1'b0;
    end else if (cnt_r == GTM_OSC_HALF_M1) begin
      cnt_r <= 4'h0;
      osc_r <= ~osc_r;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  assign osc_out = osc_r;
endmodule

// ### rtl/gtm_test_decoder.sv
// Test pin decoder with forced outputs, clear, scan chain and oscillator monitor
`timescale 1ns/100ps
module gtm_test_decoder #(
  parameter bit TEST_PINS_PRESENT = 1'b1,
  parameter bit DFT_LOGIC_PRESENT = 1'b1,
  parameter bit OSC_ON_PAD = 1'b0
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic test_mode_in,
  input wire logic parametric_output_enable_in,
  input wire logic forced_data_in,
  input wire logic [gtm_pkg::GTM_OUT_W-1:0] user_data_in,
  input wire logic [gtm_pkg::GTM_OUT_W-1:0] user_oe_in,
  input wire logic [gtm_pkg::GTM_CHAIN_W-1:0] user_d_in,
  output logic [gtm_pkg::GTM_OUT_W-1:0] pad_data_out,
  output logic [gtm_pkg::GTM_OUT_W-1:0] pad_oe_out,
  output logic [gtm_pkg::GTM_CHAIN_W-1:0] user_q_out,
  output logic oscillator_monitor_out,
  output logic iddq_quiet_out
);
  import gtm_pkg::*;
  // Two flops per tester pin before any logic reads it
  logic mode_s1_r;
  logic mode_s2_r;
  logic poe_s1_r;
  logic poe_s2_r;
  logic dat_s1_r;
  logic dat_s2_r;
  // Modelled user flip-flops, chained for scan loading
  logic [GTM_CHAIN_W-1:0] chain_r;
  // Registered pad drivers
  logic [GTM_OUT_W-1:0] pad_data_r;
  logic [GTM_OUT_W-1:0] pad_oe_r;
  // Oscillator enable, retimed monitor and quiescent flag
  logic osc_en_r;
  logic mon_r;
  logic quiet_r;
  logic osc_raw;
  // Decoded mode; lags the pins by the two sync stages
  gtm_mode_t mode_nxt;

  // Test pins come from the tester, outside this clock domain;
  // presetting the syncs high makes the block wake in normal operation
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_s1_r <= 1'b1;
      mode_s2_r <= 1'b1;
      poe_s1_r <= 1'b1;
      poe_s2_r <= 1'b1;
      dat_s1_r <= 1'b1;
      dat_s2_r <= 1'b1;
    end else begin
      mode_s1_r <= test_mode_in;
      mode_s2_r <= mode_s1_r;
      poe_s1_r <= parametric_output_enable_in;
      poe_s2_r <= poe_s1_r;
      dat_s1_r <= forced_data_in;
      dat_s2_r <= dat_s1_r;
    end
  end

  // Pin code to mode; absent pins give normal, absent test logic turns clear and scan codes to normal.
  // Each pin is synchronised on its own, so pins that do not move together
  // may show a passing mode for one clock: the tester must let codes settle.
  always_comb begin
    mode_nxt = GTM_NORMAL;
    if (!TEST_PINS_PRESENT) begin
      mode_nxt = GTM_NORMAL;
    end else if (!mode_s2_r && !poe_s2_r) begin
      mode_nxt = GTM_FORCE;
    end else if (!mode_s2_r && !dat_s2_r) begin
      mode_nxt = GTM_HIZ;
    end else if (!mode_s2_r) begin
      mode_nxt = GTM_IDDQ;
    end else if (!poe_s2_r && DFT_LOGIC_PRESENT) begin
      mode_nxt = GTM_SCAN;
    end else if (!dat_s2_r && DFT_LOGIC_PRESENT) begin
      mode_nxt = GTM_CLEAR;
    end else begin
      mode_nxt = GTM_NORMAL;
    end
  end

  // User flip-flop chain: clear, scan shift, hold in quiescence, else user load
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      chain_r <= GTM_CHAIN_RST;
    end else begin
      case (mode_nxt)
        GTM_CLEAR: chain_r <= GTM_CHAIN_RST;
        GTM_SCAN: chain_r <= {chain_r[GTM_CHAIN_W-2:0], dat_s2_r};
        GTM_IDDQ: chain_r <= chain_r;
        default: chain_r <= user_d_in;
      endcase
    end
  end

  // Clear empties the whole chain in one clock
  a_clear_all: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (mode_nxt == GTM_CLEAR) |=> (chain_r == GTM_CHAIN_RST) && !osc_en_r)
    else $error("flip-flops not cleared");
  // Scan moves the chain up by one and takes the data pin into bit 0
  a_scan_shift: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (mode_nxt == GTM_SCAN) |=> chain_r == {$past(chain_r[GTM_CHAIN_W-2:0]), $past(dat_s2_r)})
    else $error("scan shift wrong");
  // Quiescent mode freezes the chain and keeps the ring stopped
  a_iddq_static: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (mode_nxt == GTM_IDDQ) ##1 (mode_nxt == GTM_IDDQ) |=> $stable(chain_r) && !osc_en_r)
    else $error("logic not static in quiescent mode");
  // Clear code decodes only when both the pins and the extra logic exist
  a_mode_decode: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (mode_s2_r && poe_s2_r && !dat_s2_r) |-> (mode_nxt == GTM_CLEAR) == (TEST_PINS_PRESENT
    && DFT_LOGIC_PRESENT))
    else $error("clear code decoded wrongly");
  // Without test pins the user flip-flops load as in normal operation
  a_nopins_normal: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    !TEST_PINS_PRESENT |=> chain_r == $past(user_d_in))
    else $error("test code acted without test pins");
  // Without the extra logic, clear and scan codes leave the chain loading
  a_nodft_normal: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (!DFT_LOGIC_PRESENT && mode_s2_r) |=> chain_r == $past(user_d_in))
    else $error("clear or scan acted without test logic");

  // Pad drivers; registered so the pins change on a clean edge
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pad_data_r <= GTM_OUT_RST;
      pad_oe_r <= GTM_OUT_RST;
    end else begin
      case (mode_nxt)
        GTM_FORCE: begin
          pad_data_r <= {GTM_OUT_W{dat_s2_r}};
          pad_oe_r <= {GTM_OUT_W{1'b1}};
        end
        GTM_HIZ: begin
          pad_data_r <= GTM_OUT_RST;
          pad_oe_r <= GTM_OUT_RST;
        end
        default: begin
          pad_data_r <= user_data_in;
          pad_oe_r <= user_oe_in;
        end
      endcase
      // Optional pad 0 carries the oscillator instead of user logic
      if (OSC_ON_PAD) begin
        pad_data_r[0] <= osc_raw;
        pad_oe_r[0] <= 1'b1;
      end
    end
  end

  // Forced mode drives all pads, all but pad 0 when the ring is bonded, with the data pin one clock after decode
  a_force_drive: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (mode_nxt == GTM_FORCE && !OSC_ON_PAD) |=> (pad_oe_r == {GTM_OUT_W{1'b1}})
    && (pad_data_r == {GTM_OUT_W{$past(dat_s2_r)}}))
    else $error("forced data not on outputs");
  // A bonded oscillator owns pad 0 in every mode
  a_osc_pad: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    OSC_ON_PAD |=> pad_oe_r[0] && (pad_data_r[0] == $past(osc_raw)))
    else $error("oscillator not on pad");

  // Oscillator runs only in the leakage and frequency mode
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_en_r <= 1'b0;
    end else begin
      osc_en_r <= (mode_nxt == GTM_HIZ);
    end
  end

  // Monitor retimed so the pin leaves a flop; costs one clock of lag
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mon_r <= 1'b0;
    end else begin
      mon_r <= osc_raw;
    end
  end

  // Quiescent flag tells the tester when supply current may be read
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      quiet_r <= 1'b0;
    end else begin
      quiet_r <= (mode_nxt == GTM_IDDQ);
    end
  end

  gtm_ring_osc gtm_ring_osc_i (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .enable_in(osc_en_r),
    .osc_out(osc_raw)
  );

  // Every output leaves a flop directly
  assign pad_data_out = pad_data_r;
  assign pad_oe_out = pad_oe_r;
  assign user_q_out = chain_r;
  assign oscillator_monitor_out = mon_r;
  assign iddq_quiet_out = quiet_r;

  // Leakage mode floats the pads, all but pad 0 when the ring is bonded, and starts the ring
  a_hiz_outputs: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (mode_nxt == GTM_HIZ && !OSC_ON_PAD) |=> (pad_oe_r == GTM_OUT_RST) && osc_en_r)
    else $error("outputs not tri-stated");
  // Normal operation silences the monitor once the ring has drained
  a_normal_mon: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (mode_nxt == GTM_NORMAL) [*3] |=> !oscillator_monitor_out)
    else $error("monitor active in normal mode");
  // A stopped ring leaves the monitor low two clocks on
  a_osc_idle: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (!osc_en_r) [*2] |=> !oscillator_monitor_out)
    else $error("monitor moving while ring stopped");
  // Quiescent flag follows the decoded mode one clock later
  a_quiet_flag: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (mode_nxt == GTM_IDDQ) |=> iddq_quiet_out)
    else $error("quiescent flag missing");
endmodule

// ### test/gtm_ate_model.sv
// Tester model that drives the three test pins
`timescale 1ns/100ps
module gtm_ate_model (
  input wire logic clk_sys_in,
  input wire logic [2:0] code_in,
  output logic test_mode_out,
  output logic poe_out,
  output logic fdata_out
);
  // Pins move just after an edge, so a scan bit lasts one clock
  always_ff @(posedge clk_sys_in) begin
    {test_mode_out, poe_out, fdata_out} <= code_in;
  end
endmodule

// ### test/gtm_test_decoder_bench.sv
// Self-checking bench for the test mode decoder
`timescale 1ns/100ps
module gtm_test_decoder_bench;
  import gtm_pkg::*;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [2:0] code = 3'h7;
  logic tm, poe, fd, osc, quiet;
  logic [15:0] ud = 16'h0000, uoe = 16'h0000, udd = 16'h0000;
  logic [15:0] pd, pad_oe, q;
  logic [15:0] pd_nd, oe_nd, q_nd, pd_np, q_np;
  int n_mismatch = 0;
  int checks_done = 0;
  // Free-running system clock
  initial begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  gtm_ate_model gtm_ate_model_i (.clk_sys_in(clk_sys_in), .code_in(code),
    .test_mode_out(tm), .poe_out(poe), .fdata_out(fd));
  gtm_test_decoder gtm_test_decoder_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .test_mode_in(tm), .parametric_output_enable_in(poe), .forced_data_in(fd),
    .user_data_in(ud), .user_oe_in(uoe), .user_d_in(udd), .pad_data_out(pd),
    .pad_oe_out(pad_oe), .user_q_out(q), .oscillator_monitor_out(osc),
    .iddq_quiet_out(quiet));
  // Variant without clear and scan logic, ring bonded to pad 0
  gtm_test_decoder #(.DFT_LOGIC_PRESENT(1'b0), .OSC_ON_PAD(1'b1))
    gtm_test_decoder_nodft_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .test_mode_in(tm), .parametric_output_enable_in(poe), .forced_data_in(fd),
    .user_data_in(ud), .user_oe_in(uoe), .user_d_in(udd), .pad_data_out(pd_nd),
    .pad_oe_out(oe_nd), .user_q_out(q_nd), .oscillator_monitor_out(),
    .iddq_quiet_out());
  // Variant without test pins
  gtm_test_decoder #(.TEST_PINS_PRESENT(1'b0))
    gtm_test_decoder_nopins_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .test_mode_in(tm), .parametric_output_enable_in(poe), .forced_data_in(fd),
    .user_data_in(ud), .user_oe_in(uoe), .user_d_in(udd), .pad_data_out(pd_np),
    .pad_oe_out(), .user_q_out(q_np), .oscillator_monitor_out(),
    .iddq_quiet_out());
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Tester model adds one edge, pin syncs two more, outputs one more
  task automatic go(input logic [2:0] c, input logic [15:0] d, input logic [15:0] dd);
    @(posedge clk_sys_in);
    code <= c;
    ud <= d;
    uoe <= 16'h0FF0;
    udd <= dd;
    repeat (6) @(posedge clk_sys_in);
    #1;
  endtask
  // Monitor changes every 4 clocks, so 16 clocks give 4 changes
  task automatic toggles(input logic [15:0] exp);
    int n;
    int n_pad;
    logic last;
    logic last_pad;
    n = 0;
    n_pad = 0;
    last = osc;
    last_pad = pd_nd[0];
    repeat (16) begin
      @(posedge clk_sys_in);
      #1;
      if (osc !== last) n++;
      if (pd_nd[0] !== last_pad) n_pad++;
      last = osc;
      last_pad = pd_nd[0];
    end
    chk(16'(n), exp);
    chk(16'(n_pad), exp);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    logic [15:0] w;
    w = 16'hB38E;
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    go(3'h7, 16'hA5C3, 16'h3C5A);
    chk(pd, 16'hA5C3);
    chk(pad_oe, 16'h0FF0);
    chk(q, 16'h3C5A);
    chk(pd_nd, 16'hA5C2);
    chk(oe_nd, 16'h0FF1);
    toggles(16'h0000);
    $display("test normal done");
    go(3'h1, 16'h0000, 16'h3C5A);
    chk(pd, 16'hFFFF);
    chk(pad_oe, 16'hFFFF);
    chk(pd_np, 16'h0000);
    go(3'h0, 16'hFFFF, 16'h3C5A);
    chk(pd, 16'h0000);
    $display("test force done");
    go(3'h2, 16'hA5C3, 16'h3C5A);
    chk(pad_oe, 16'h0000);
    chk(oe_nd, 16'h0001);
    toggles(16'h0004);
    $display("test hiz done");
    go(3'h7, 16'hA5C3, 16'h3C5A);
    go(3'h3, 16'hA5C3, 16'h3C5A);
    go(3'h3, 16'hA5C3, 16'h1234);
    chk(q, 16'h3C5A);
    chk({15'h0000, quiet}, 16'h0001);
    toggles(16'h0000);
    $display("test quiet done");
    go(3'h7, 16'hA5C3, 16'hFFFF);
    go(3'h6, 16'hA5C3, 16'hFFFF);
    chk(q, 16'h0000);
    chk(q_nd, 16'hFFFF);
    chk(q_np, 16'hFFFF);
    toggles(16'h0000);
    $display("test clear done");
    go(3'h7, 16'hA5C3, 16'h0000);
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk_sys_in);
      code <= {2'h2, w[i]};
      udd <= 16'hFFFF;
    end
    go(3'h3, 16'hA5C3, 16'hFFFF);
    chk(q, w);
    chk(q_nd, 16'hFFFF);
    chk(q_np, 16'hFFFF);
    $display("test scan done");
    end_sim();
  end
endmodule
